// File: hw/word_codec_pkg.sv
// shared constants for the network word format codec
package word_codec_pkg;

    // ------------------------------------------------------------
    // word and value widths
    // ------------------------------------------------------------
    localparam int WORD_W  = 16;
    localparam int VALUE_W = 32;

    // ------------------------------------------------------------
    // format and word order encodings
    // ------------------------------------------------------------
    localparam logic FMT_MULTIWORD = 1'b0;
    localparam logic FMT_INT32     = 1'b1;
    localparam logic ENDIAN_LITTLE = 1'b0;
    localparam logic ENDIAN_BIG    = 1'b1;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic RESET_FMT    = FMT_MULTIWORD;
    localparam logic RESET_ENDIAN = ENDIAN_LITTLE;

    // ------------------------------------------------------------
    // multi-word split and legal range
    // ------------------------------------------------------------
    localparam logic signed [31:0] MW_SCALE  = 32'sd1000;
    localparam logic signed [31:0] MW_MIN    = -32'sd32768000;
    localparam logic signed [31:0] MW_MAX    = 32'sd32767999;
    localparam logic signed [15:0] MW_LO_MAX = 16'sd999;
    localparam logic signed [15:0] MW_LO_MIN = -16'sd999;

    // ------------------------------------------------------------
    // latency of both directions in clock cycles
    // ------------------------------------------------------------
    localparam int CODEC_LATENCY = 1;

endpackage

// File: hw/word_pair_packer.sv
// packs one signed 32-bit value into two 16-bit network words
module word_pair_packer
    import word_codec_pkg::*;
(
    input  wire logic [word_codec_pkg::VALUE_W-1:0] value,
    input  wire logic                               fmt,
    input  wire logic                               endian,
    output logic      [word_codec_pkg::WORD_W-1:0]  word_lo_addr,
    output logic      [word_codec_pkg::WORD_W-1:0]  word_hi_addr,
    output logic                                    range_err
);

    logic signed [31:0] sval;
    logic signed [31:0] quot;
    logic signed [31:0] rem;

    // ------------------------------------------------------------
    // thousands split, truncating toward zero
    // ------------------------------------------------------------
    // truncation keeps the sign on both words for negative values
    always_comb begin
        sval = $signed(value);
        quot = sval / MW_SCALE;                       // RULE3
        rem  = sval - quot * MW_SCALE;                // RULE13
    end

    // ------------------------------------------------------------
    // word placement per format and order
    // ------------------------------------------------------------
    always_comb begin
        range_err = 1'b0;
        if (fmt == FMT_INT32) begin                   // RULE6
            if (endian == ENDIAN_LITTLE) begin        // RULE7
                word_lo_addr = value[15:0];
                word_hi_addr = value[31:16];
            end else begin
                word_lo_addr = value[31:16];
                word_hi_addr = value[15:0];
            end
        end else begin
            word_lo_addr = quot[15:0];                // RULE3
            word_hi_addr = rem[15:0];
            // beyond the range the words are not meaningful; only flagged
            range_err = (sval < MW_MIN) || (sval > MW_MAX); // RULE4 RULE5
        end
    end

endmodule

// File: hw/network_word_codec.sv
// network word format codec: value to word pair and word pair to value
//
// Contract
// RULE1 - data travels as 16-bit words, pairs for 32-bit
// RULE2 - multi-word format is the default
// RULE3 - low address thousands, high address remainder
// RULE4 - multi-word range -32768000 through 32767999
// RULE5 - overflowed multi-word results are indeterminate
// RULE6 - signed 32-bit binary format also supported
// RULE7 - word order selects least or most first
// RULE8 - replies use the host's own word order
// RULE9 - host picks protocol-typical default word order
// RULE10 - input and output formats configured separately
// RULE11 - host should use 32-bit for continuous rotation
// RULE12 - description-file hosts use 32-bit little endian
// RULE13 - negative multi-word: both words signed, small remainder
module network_word_codec
    import word_codec_pkg::*;
(
    input  wire logic                               ref_clk,
    input  wire logic                               nrst,
    input  wire logic                               ce,
    input  wire logic                               cfg_wr,
    input  wire logic                               cfg_in_fmt,
    input  wire logic                               cfg_out_fmt,
    input  wire logic                               cfg_endian,
    input  wire logic                               tx_valid,
    input  wire logic [word_codec_pkg::VALUE_W-1:0] tx_value,
    input  wire logic                               rx_valid,
    input  wire logic [word_codec_pkg::WORD_W-1:0]  rx_word0,
    input  wire logic [word_codec_pkg::WORD_W-1:0]  rx_word1,
    output logic                                    in_fmt,
    output logic                                    out_fmt,
    output logic                                    endian,
    output logic                                    in_valid,
    output logic      [word_codec_pkg::WORD_W-1:0]  in_word0,
    output logic      [word_codec_pkg::WORD_W-1:0]  in_word1,
    output logic                                    in_range_err,
    output logic                                    out_valid,
    output logic      [word_codec_pkg::VALUE_W-1:0] out_value,
    output logic                                    out_range_err
);

    import word_codec_pkg::*;

    // ------------------------------------------------------------
    // configuration state
    // ------------------------------------------------------------
    logic in_fmt_r;
    logic in_fmt_nxt;
    logic out_fmt_r;
    logic out_fmt_nxt;
    logic endian_r;
    logic endian_nxt;

    // each direction has its own format; one shared word order
    always_comb begin
        in_fmt_nxt  = in_fmt_r;
        out_fmt_nxt = out_fmt_r;
        endian_nxt  = endian_r;
        if (cfg_wr) begin
            in_fmt_nxt  = cfg_in_fmt;                 // RULE10
            out_fmt_nxt = cfg_out_fmt;                // RULE10
            endian_nxt  = cfg_endian;                 // RULE8
        end
    end

    // reset lands in multi-word format
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            in_fmt_r  <= RESET_FMT;                   // RULE2
            out_fmt_r <= RESET_FMT;                   // RULE2
            endian_r  <= RESET_ENDIAN;
        end else if (ce) begin
            in_fmt_r  <= in_fmt_nxt;
            out_fmt_r <= out_fmt_nxt;
            endian_r  <= endian_nxt;
        end
    end

    assign in_fmt  = in_fmt_r;
    assign out_fmt = out_fmt_r;
    assign endian  = endian_r;

    // ------------------------------------------------------------
    // device to host: value into two words
    // ------------------------------------------------------------
    logic [WORD_W-1:0] pk_w0;
    logic [WORD_W-1:0] pk_w1;
    logic              pk_err;

    word_pair_packer u_packer (
        .value        (tx_value),
        .fmt          (in_fmt_r),
        .endian       (endian_r),
        .word_lo_addr (pk_w0),
        .word_hi_addr (pk_w1),
        .range_err    (pk_err)
    );

    logic              in_valid_r;
    logic              in_valid_nxt;
    logic [WORD_W-1:0] in_word0_r;
    logic [WORD_W-1:0] in_word0_nxt;
    logic [WORD_W-1:0] in_word1_r;
    logic [WORD_W-1:0] in_word1_nxt;
    logic              in_err_r;
    logic              in_err_nxt;

    // words hold their last value between requests
    always_comb begin
        in_valid_nxt = tx_valid;
        in_word0_nxt = in_word0_r;
        in_word1_nxt = in_word1_r;
        in_err_nxt   = in_err_r;
        if (tx_valid) begin
            in_word0_nxt = pk_w0;                     // RULE1
            in_word1_nxt = pk_w1;                     // RULE1
            in_err_nxt   = pk_err;                    // RULE5
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            in_valid_r <= 1'b0;
            in_word0_r <= '0;
            in_word1_r <= '0;
            in_err_r   <= 1'b0;
        end else if (ce) begin
            in_valid_r <= in_valid_nxt;
            in_word0_r <= in_word0_nxt;
            in_word1_r <= in_word1_nxt;
            in_err_r   <= in_err_nxt;
        end
    end

    assign in_valid     = in_valid_r;
    assign in_word0     = in_word0_r;
    assign in_word1     = in_word1_r;
    assign in_range_err = in_err_r;

    // ------------------------------------------------------------
    // host to device: two words into value
    // ------------------------------------------------------------
    logic signed [31:0] mw_hi;
    logic signed [31:0] mw_lo;
    logic signed [31:0] dec_value;
    logic               dec_err;

    // the remainder word is checked since a full product never overflows
    always_comb begin
        mw_hi   = {{16{rx_word0[15]}}, rx_word0};
        mw_lo   = {{16{rx_word1[15]}}, rx_word1};
        dec_err = 1'b0;
        if (out_fmt_r == FMT_INT32) begin             // RULE6
            if (endian_r == ENDIAN_LITTLE) begin      // RULE7
                dec_value = {rx_word1, rx_word0};
            end else begin
                dec_value = {rx_word0, rx_word1};
            end
        end else begin
            dec_value = mw_hi * MW_SCALE + mw_lo;     // RULE3
            dec_err   = ($signed(rx_word1) > MW_LO_MAX) ||
                        ($signed(rx_word1) < MW_LO_MIN) ||
                        (dec_value < MW_MIN) || (dec_value > MW_MAX); // RULE4 RULE13
        end
    end

    logic               out_valid_r;
    logic               out_valid_nxt;
    logic [VALUE_W-1:0] out_value_r;
    logic [VALUE_W-1:0] out_value_nxt;
    logic               out_err_r;
    logic               out_err_nxt;

    always_comb begin
        out_valid_nxt = rx_valid;
        out_value_nxt = out_value_r;
        out_err_nxt   = out_err_r;
        if (rx_valid) begin
            out_value_nxt = dec_value;
            out_err_nxt   = dec_err;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            out_valid_r <= 1'b0;
            out_value_r <= '0;
            out_err_r   <= 1'b0;
        end else if (ce) begin
            out_valid_r <= out_valid_nxt;
            out_value_r <= out_value_nxt;
            out_err_r   <= out_err_nxt;
        end
    end

    assign out_valid     = out_valid_r;
    assign out_value     = out_value_r;
    assign out_range_err = out_err_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    property p_cfg_hold;
        ce && !cfg_wr |=> $stable(in_fmt) && $stable(out_fmt) && $stable(endian);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("config changed without write"); // RULE10

    property p_int32_little;
        ce && tx_valid && in_fmt == FMT_INT32 && endian == ENDIAN_LITTLE
            |=> {in_word1, in_word0} == $past(tx_value);
    endproperty
    a_int32_little: assert property (p_int32_little) else $error("little endian words wrong"); // RULE7

    property p_int32_big;
        ce && tx_valid && in_fmt == FMT_INT32 && endian == ENDIAN_BIG
            |=> {in_word0, in_word1} == $past(tx_value);
    endproperty
    a_int32_big: assert property (p_int32_big) else $error("big endian words wrong"); // RULE7

    property p_mw_roundtrip;
        ce && tx_valid && in_fmt == FMT_MULTIWORD &&
            $signed(tx_value) >= MW_MIN && $signed(tx_value) <= MW_MAX
            |=> !in_range_err && ($signed(in_word0) * 32'sd1000 + $signed(in_word1))
                == $signed($past(tx_value));
    endproperty
    a_mw_roundtrip: assert property (p_mw_roundtrip) else $error("multi-word split wrong"); // RULE3

    property p_mw_remainder;
        ce && tx_valid && in_fmt == FMT_MULTIWORD && !pk_err
            |=> $signed(in_word1) <= 16'sd999 && $signed(in_word1) >= -16'sd999 &&
                ($signed(in_word1) == 16'sd0 || in_word1[15] == $past(tx_value[31]));
    endproperty
    a_mw_remainder: assert property (p_mw_remainder) else $error("remainder sign or size wrong"); // RULE13

    property p_mw_overflow;
        ce && tx_valid && in_fmt == FMT_MULTIWORD && $signed(tx_value) > 32'sd32767999
            |=> in_range_err;
    endproperty
    a_mw_overflow: assert property (p_mw_overflow) else $error("overflow not flagged"); // RULE4

    property p_dec_echo_order;
        ce && rx_valid && out_fmt == FMT_INT32 && endian == ENDIAN_BIG
            |=> out_valid && out_value == {$past(rx_word0), $past(rx_word1)};
    endproperty
    a_dec_echo_order: assert property (p_dec_echo_order) else $error("decode order wrong"); // RULE8

    property p_dec_multiword;
        ce && rx_valid && out_fmt == FMT_MULTIWORD
            |=> $signed(out_value) ==
                $signed($past(rx_word0)) * 32'sd1000 + $signed($past(rx_word1));
    endproperty
    a_dec_multiword: assert property (p_dec_multiword) else $error("multi-word decode wrong"); // RULE3

    property p_valid_latency;
        ce && tx_valid ##1 ce && !tx_valid |=> $fell(in_valid);
    endproperty
    a_valid_latency: assert property (p_valid_latency) else $error("valid not one cycle"); // RULE1

endmodule

// File: verification/host_word_model.sv
// host controller model that writes word pairs into the codec
module host_word_model
    import word_codec_pkg::*;
(
    input  wire logic                               ref_clk,
    output logic                                    rx_valid,
    output logic      [word_codec_pkg::WORD_W-1:0]  rx_word0,
    output logic      [word_codec_pkg::WORD_W-1:0]  rx_word1
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        rx_valid = 1'b0;
        rx_word0 = 16'h0000;
        rx_word1 = 16'h0000;
    end

    // a pair is held across its sampling edge; the caller releases it later
    task automatic raw(input logic [15:0] w0, input logic [15:0] w1);
        rx_valid = 1'b1;
        rx_word0 = w0;
        rx_word1 = w1;
        @(posedge ref_clk);
        #1;
    endtask

    // released words turn to junk so that stale data never passes
    task automatic done();
        rx_valid = 1'b0;
        rx_word0 = ~rx_word0;
        rx_word1 = ~rx_word1;
    endtask

    // host-side layout of one value, toward-zero split for multi-word
    task automatic put(input logic [31:0] v, input logic fmt, input logic big);
        logic signed [31:0] s;
        s = signed'(v);
        if (fmt == FMT_MULTIWORD) begin
            raw(16'(s / MW_SCALE), 16'(s % MW_SCALE));
        end else if (big == ENDIAN_BIG) begin
            raw(v[31:16], v[15:0]);
        end else begin
            raw(v[15:0], v[31:16]);
        end
    endtask
endmodule

// File: verification/network_word_format_codec_bench.sv
// self-checking bench for the network word format codec
module network_word_format_codec_bench import word_codec_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic        ref_clk, nrst, ce, cfg_wr, cfg_in_fmt, cfg_out_fmt, cfg_endian;
    logic        tx_valid, rx_valid, in_fmt, out_fmt, endian;
    logic        in_valid, in_range_err, out_valid, out_range_err;
    logic [31:0] tx_value, out_value;
    logic [15:0] rx_word0, rx_word1, in_word0, in_word1;
    int          miscompares = 0;
    int          n_checks = 0;

    network_word_codec i_network_word_codec (.ref_clk(ref_clk), .nrst(nrst), .ce(ce),
        .cfg_wr(cfg_wr), .cfg_in_fmt(cfg_in_fmt), .cfg_out_fmt(cfg_out_fmt),
        .cfg_endian(cfg_endian), .tx_valid(tx_valid), .tx_value(tx_value),
        .rx_valid(rx_valid), .rx_word0(rx_word0), .rx_word1(rx_word1), .in_fmt(in_fmt),
        .out_fmt(out_fmt), .endian(endian), .in_valid(in_valid), .in_word0(in_word0),
        .in_word1(in_word1), .in_range_err(in_range_err), .out_valid(out_valid),
        .out_value(out_value), .out_range_err(out_range_err));

    host_word_model i_host_word_model (.ref_clk(ref_clk), .rx_valid(rx_valid),
        .rx_word0(rx_word0), .rx_word1(rx_word1));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        if (miscompares == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic cfg(input logic fi, input logic fo, input logic e);
        cfg_wr = 1'b1;
        cfg_in_fmt = fi;
        cfg_out_fmt = fo;
        cfg_endian = e;
        @(posedge ref_clk);
        #1;
        cfg_wr = 1'b0;
    endtask

    // tx_valid stays up so packs can follow back to back
    task automatic pack(input logic [31:0] v, input logic [15:0] w0, w1, input logic err);
        tx_valid = 1'b1;
        tx_value = v;
        @(posedge ref_clk);
        #1;
        check("in_valid", 32'(in_valid), 32'h00000001);
        check("in_range_err", 32'(in_range_err), 32'(err));
        if (!err) begin
            check("in_word0", 32'(in_word0), 32'(w0));
            check("in_word1", 32'(in_word1), 32'(w1));
        end
    endtask

    task automatic unpack(input logic [31:0] v, input logic fmt, input logic big);
        i_host_word_model.put(v, fmt, big);
        check("out_valid", 32'(out_valid), 32'h00000001);
        check("out_value", out_value, v);
        check("out_range_err", 32'(out_range_err), 32'h00000000);
    endtask

    // both requests dropped; both answer valids fall one cycle later
    task automatic idle();
        tx_valid = 1'b0;
        i_host_word_model.done();
        @(posedge ref_clk);
        #1;
        check("in_valid low", 32'(in_valid), 32'h00000000);
        check("out_valid low", 32'(out_valid), 32'h00000000);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_defaults();
        check("in_fmt", 32'(in_fmt), 32'(FMT_MULTIWORD));
        check("out_fmt", 32'(out_fmt), 32'(FMT_MULTIWORD));
        check("endian", 32'(endian), 32'(RESET_ENDIAN));
        pack(32'h00003039, 16'h000C, 16'h0159, 1'b0);
    endtask

    // signs, both range edges and both overflows, back to back
    task automatic t_multi_pack();
        pack(32'hFFFFCFC7, 16'hFFF4, 16'hFEA7, 1'b0);
        pack(32'h01F3FFFF, 16'h7FFF, 16'h03E7, 1'b0);
        pack(32'hFE0C0000, 16'h8000, 16'h0000, 1'b0);
        pack(32'h01F40000, 16'h0000, 16'h0000, 1'b1);
        pack(32'hFE0BFFFF, 16'h0000, 16'h0000, 1'b1);
        idle();
    endtask

    task automatic t_int32();
        cfg(FMT_INT32, FMT_INT32, ENDIAN_LITTLE);
        pack(32'h0001E240, 16'hE240, 16'h0001, 1'b0);
        unpack(32'h0001E240, FMT_INT32, ENDIAN_LITTLE);
        cfg(FMT_INT32, FMT_INT32, ENDIAN_BIG);
        pack(32'h0001E240, 16'h0001, 16'hE240, 1'b0);
        unpack(32'hFFFE1DC0, FMT_INT32, ENDIAN_BIG);
        idle();
    endtask

    // opposite formats in the two directions at the same time
    task automatic t_independent();
        cfg(FMT_INT32, FMT_MULTIWORD, ENDIAN_BIG);
        tx_valid = 1'b1;
        tx_value = 32'h0001E240;
        unpack(32'h00003039, FMT_MULTIWORD, ENDIAN_BIG);
        check("in_word0", 32'(in_word0), 32'h00000001);
        check("in_word1", 32'(in_word1), 32'h0000E240);
        cfg(FMT_MULTIWORD, FMT_INT32, ENDIAN_LITTLE);
        pack(32'h00003039, 16'h000C, 16'h0159, 1'b0);
        unpack(32'h0001E240, FMT_INT32, ENDIAN_LITTLE);
        idle();
    endtask

    task automatic t_multi_unpack();
        cfg(FMT_MULTIWORD, FMT_MULTIWORD, ENDIAN_LITTLE);
        unpack(32'hFFFFCFC7, FMT_MULTIWORD, ENDIAN_LITTLE);
        unpack(32'hFE0C0000, FMT_MULTIWORD, ENDIAN_LITTLE);
        // a remainder of -1 under the most negative thousands word pushes the value below the range
        i_host_word_model.raw(16'h8000, 16'hFFFF);
        check("out_range_err", 32'(out_range_err), 32'h00000001);
        i_host_word_model.raw(16'h000C, 16'h03E8);
        check("out_range_err", 32'(out_range_err), 32'h00000001);
        idle();
    endtask

    // a frozen clock enable must swallow the request edge
    task automatic t_stall();
        ce = 1'b0;
        tx_valid = 1'b1;
        tx_value = 32'h0001E240;
        @(posedge ref_clk);
        #1;
        check("in_valid stalled", 32'(in_valid), 32'h00000000);
        check("in_word0 held", 32'(in_word0), 32'h0000000C);
        ce = 1'b1;
        pack(32'h00003039, 16'h000C, 16'h0159, 1'b0);
        idle();
    endtask

    // a mid-run reset must drop a changed config back to its defaults
    task automatic t_reset();
        cfg(FMT_INT32, FMT_INT32, ENDIAN_BIG);
        check("endian", 32'(endian), 32'(ENDIAN_BIG));
        tx_valid = 1'b1;
        tx_value = 32'h0001E240;
        nrst = 1'b0;
        @(posedge ref_clk);
        #1;
        check("in_fmt reset", 32'(in_fmt), 32'(FMT_MULTIWORD));
        check("out_fmt reset", 32'(out_fmt), 32'(FMT_MULTIWORD));
        check("endian reset", 32'(endian), 32'(RESET_ENDIAN));
        check("in_valid reset", 32'(in_valid), 32'h00000000);
        nrst = 1'b1;
        pack(32'h0001E240, 16'h007B, 16'h01C8, 1'b0);
        idle();
    endtask

    // ------------------------------------------------------------
    // clock, reset, sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        cfg_wr = 1'b0;
        cfg_in_fmt = 1'b0;
        cfg_out_fmt = 1'b0;
        cfg_endian = 1'b0;
        tx_valid = 1'b0;
        tx_value = 32'h00000000;
        repeat (10) @(posedge ref_clk);
        #1;
        nrst = 1'b1;
        t_defaults();
        t_multi_pack();
        t_int32();
        t_independent();
        t_multi_unpack();
        t_stall();
        t_reset();
        conclude();
    end

    // the sequence needs well under a hundred cycles
    initial begin
        #20000;
        miscompares++;
        conclude();
    end
endmodule
